// ---- pkg/sdl_defines.vh ----
`ifndef SDL_DEFINES_VH
`define SDL_DEFINES_VH

// Character shape
`define SDL_DATA_BITS      4'h8
`define SDL_STOP_IDX       4'h9
// Training character and commands
`define SDL_SYNC_CHAR      8'h80
`define SDL_CMD_RD_STAT    8'h02
`define SDL_CMD_WR_CTL     8'h04
`define SDL_CMD_RD_CTL     8'h05
`define SDL_BRK_OPCODE     8'h00
// Baud divider limits in system clocks per bit
`define SDL_DIV_MIN        10'h004
`define SDL_DIV_MAX        10'h200
// Sync low run is eight bit times
`define SDL_SYNC_MIN       13'h0020
`define SDL_SYNC_MAX       13'h1000
// Outgoing break length in system clocks
`define SDL_ERR_BRK_CYC    13'h1000
// Control register fields and reset value
`define SDL_CTL_HALT       7
`define SDL_CTL_BRKEN      6
`define SDL_CTL_BREAK_LOOP_BIT      5
`define SDL_CTL_RESET      8'h00
// Status register fields
`define SDL_STAT_HALT      7
`define SDL_STAT_LOOP      5
`define SDL_STAT_LOCK      4

`endif

// ---- rtl/sdl_byte_fifo.v ----
`timescale 1ns/1ps
module sdl_byte_fifo (
   input  wire       core_clk,
   input  wire       rst_n,
   input  wire       flush,
   input  wire [7:0] in_data,
   input  wire       in_valid,
   output wire       in_ready,
   output wire [7:0] out_data,
   output wire       out_valid,
   input  wire       out_ready
);
   reg [7:0] mem [0:1];
   reg       wr_ptr;
   reg       rd_ptr;
   reg [1:0] fill;

   wire push = in_valid & in_ready;
   wire pop  = out_valid & out_ready;

   assign in_ready  = (fill != 2'h2);
   assign out_valid = (fill != 2'h0);
   assign out_data  = mem[rd_ptr];

   always @(posedge core_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         fill   <= 2'h0;
      end else if (flush) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         fill   <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         if (push && !pop) begin
            fill <= fill + 2'h1;
         end else if (pop && !push) begin
            fill <= fill - 2'h1;
         end
      end
   end
endmodule // sdl_byte_fifo

// ---- rtl/sdl_debug_link.v ----
`timescale 1ns/1ps
`include "sdl_defines.vh"

module sdl_debug_link (
   input  wire       core_clk,
   input  wire       rst_n,
   input  wire       debug_wire_pin_in,
   output reg        debug_wire_pin_out,
   output reg        debug_wire_pin_oe,
   input  wire       break_opcode_decode,
   input  wire       stop_mode,
   input  wire       read_lock_option,
   output reg  [7:0] debug_control_reg,
   output reg  [7:0] debug_status_reg,
   output reg        cpu_fetch_stop,
   output reg        cpu_halt_exit,
   output reg        wdt_refresh,
   output reg        cpu_break_loop,
   output reg        sys_reset_req,
   output reg        link_error
);
   localparam [6:0] L_UNTRAINED = 7'h01;
   localparam [6:0] L_MEASURE   = 7'h02;
   localparam [6:0] L_IDLE      = 7'h04;
   localparam [6:0] L_RX        = 7'h08;
   localparam [6:0] L_TX        = 7'h10;
   localparam [6:0] L_ERRBRK    = 7'h20;
   localparam [6:0] L_WAITHI    = 7'h40;

   localparam [2:0] C_IDLE = 3'h1;
   localparam [2:0] C_DATA = 3'h2;
   localparam [2:0] C_RESP = 3'h4;

   function [9:0] half_of;
      input [9:0] v;
      begin
         half_of = {1'b0, v[9:1]};
      end
   endfunction

   reg        pin_s1;
   reg        pin_s2;
   reg [6:0]  lstate;
   reg [2:0]  cstate;
   reg [12:0] cnt;
   reg [9:0]  bit_time;
   reg [13:0] brk_lim;
   reg [13:0] low_cnt;
   reg [3:0]  bitn;
   reg [7:0]  rx_sh;
   reg [9:0]  tx_sh;
   reg        rx_push;
   reg [7:0]  rx_byte;
   reg        tx_req;
   reg [7:0]  tx_byte;
   reg        wr_ctl;
   reg [7:0]  wr_data;
   reg        flush;
   reg [1:0]  boot_cnt;
   reg [7:0]  next_ctl;

   wire [7:0] fifo_data;
   wire       fifo_valid;
   wire       fifo_ready = (cstate != C_RESP) & ~flush;
   wire       looping = cpu_break_loop;
   // A 0x00 character is exactly nine bits low; only a longer run is a break
   wire       is_break = (low_cnt > brk_lim);

   sdl_byte_fifo u_rx_fifo (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .flush     (flush),
      .in_data   (rx_byte),
      .in_valid  (rx_push),
      .in_ready  (),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_ready)
   );

   // Pin comes from outside; two flops before any use
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1 <= 1'b1;
         pin_s2 <= 1'b1;
      end else begin
         pin_s1 <= debug_wire_pin_in;
         pin_s2 <= pin_s1;
      end
   end

   // Continuous low run, used for break detection
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt <= 14'h0000;
      end else if (pin_s2) begin
         low_cnt <= 14'h0000;
      end else if (low_cnt != 14'h3fff) begin
         low_cnt <= low_cnt + 14'h0001;
      end
   end

   // Link engine and command decoder share one process so abort is atomic
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lstate             <= L_UNTRAINED;
         cstate             <= C_IDLE;
         cnt                <= 13'h0000;
         bit_time           <= `SDL_DIV_MAX;
         brk_lim            <= 14'h3fff;
         bitn               <= 4'h0;
         rx_sh              <= 8'h00;
         tx_sh              <= 10'h3ff;
         rx_push            <= 1'b0;
         rx_byte            <= 8'h00;
         tx_req             <= 1'b0;
         tx_byte            <= 8'h00;
         wr_ctl             <= 1'b0;
         wr_data            <= 8'h00;
         flush              <= 1'b0;
         link_error         <= 1'b0;
         debug_wire_pin_oe  <= 1'b0;
         debug_wire_pin_out <= 1'b0;
      end else begin
         rx_push            <= 1'b0;
         wr_ctl             <= 1'b0;
         flush              <= 1'b0;
         link_error         <= 1'b0;
         debug_wire_pin_out <= 1'b0; // only ever pulls low
         // Command decoder
         if (fifo_valid && fifo_ready) begin
            case (cstate)
               C_IDLE: begin
                  if (fifo_data == `SDL_CMD_WR_CTL) begin
                     cstate <= C_DATA;
                  end else if (fifo_data == `SDL_CMD_RD_STAT) begin
                     tx_byte <= debug_status_reg;
                     tx_req  <= 1'b1;
                     cstate  <= C_RESP;
                  end else if (fifo_data == `SDL_CMD_RD_CTL) begin
                     tx_byte <= debug_control_reg;
                     tx_req  <= 1'b1;
                     cstate  <= C_RESP;
                  end else begin
                     // Memory and CPU commands are not served here, looping or not
                     cstate <= C_IDLE;
                  end
               end
               C_DATA: begin
                  wr_ctl  <= 1'b1;
                  wr_data <= fifo_data;
                  cstate  <= C_IDLE;
               end
               default: begin
                  cstate <= C_IDLE;
               end
            endcase
         end
         case (lstate)
            L_UNTRAINED: begin
               debug_wire_pin_oe <= 1'b0;
               if (!pin_s2) begin
                  cnt    <= 13'h0001;
                  lstate <= L_MEASURE;
               end
            end
            L_MEASURE: begin
               if (pin_s2) begin
                  // Eight low bits: bit time is the run divided by eight
                  if (cnt < `SDL_SYNC_MIN) begin
                     lstate <= L_UNTRAINED;
                  end else begin
                     bit_time <= cnt[12:3];
                     brk_lim  <= {1'b0, cnt} + {4'h0, cnt[12:3]};
                     lstate   <= L_IDLE;
                  end
               end else if (cnt >= `SDL_SYNC_MAX) begin
                  // Slower than divide 512 cannot be a sync; treat as break
                  cnt               <= 13'h0000;
                  debug_wire_pin_oe <= 1'b1;
                  lstate            <= L_ERRBRK;
               end else begin
                  cnt <= cnt + 13'h0001;
               end
            end
            L_IDLE: begin
               debug_wire_pin_oe <= 1'b0;
               if (!pin_s2) begin
                  cnt    <= {3'h0, half_of(bit_time)};
                  bitn   <= 4'h0;
                  lstate <= L_RX;
               end else if (tx_req) begin
                  tx_sh             <= {1'b1, tx_byte, 1'b0};
                  tx_req            <= 1'b0;
                  bitn              <= 4'h0;
                  cnt               <= {3'h0, bit_time} - 13'h0001;
                  debug_wire_pin_oe <= 1'b1;
                  lstate            <= L_TX;
               end
            end
            L_RX: begin
               if (is_break) begin
                  cnt               <= 13'h0000;
                  debug_wire_pin_oe <= 1'b1;
                  link_error        <= 1'b1;
                  flush             <= 1'b1;
                  cstate            <= C_IDLE;
                  tx_req            <= 1'b0;
                  lstate            <= L_ERRBRK;
               end else if (cnt != 13'h0000) begin
                  cnt <= cnt - 13'h0001;
               end else if (bitn == 4'h0 && pin_s2) begin
                  lstate <= L_IDLE; // Glitch, not a start bit
               end else if (bitn == `SDL_STOP_IDX) begin
                  if (!pin_s2) begin
                     cnt               <= 13'h0000;
                     debug_wire_pin_oe <= 1'b1;
                     link_error        <= 1'b1;
                     flush             <= 1'b1;
                     cstate            <= C_IDLE;
                     tx_req            <= 1'b0;
                     lstate            <= L_ERRBRK;
                  end else begin
                     rx_byte <= rx_sh;
                     rx_push <= 1'b1;
                     lstate  <= L_IDLE;
                  end
               end else begin
                  if (bitn != 4'h0) begin
                     rx_sh <= {pin_s2, rx_sh[7:1]}; // LSB first
                  end
                  bitn <= bitn + 4'h1;
                  cnt  <= {3'h0, bit_time} - 13'h0001;
               end
            end
            L_TX: begin
               // Synchroniser lag limits this check to divides of five or more
               if (tx_sh[0] && !pin_s2 && cnt == {3'h0, half_of(bit_time)}) begin
                  cnt               <= 13'h0000;
                  debug_wire_pin_oe <= 1'b1;
                  link_error        <= 1'b1;
                  flush             <= 1'b1;
                  cstate            <= C_IDLE;
                  lstate            <= L_ERRBRK;
               end else if (cnt != 13'h0000) begin
                  cnt <= cnt - 13'h0001;
               end else if (bitn == `SDL_STOP_IDX) begin
                  debug_wire_pin_oe <= 1'b0;
                  cstate            <= C_IDLE;
                  lstate            <= L_IDLE;
               end else begin
                  tx_sh             <= {1'b1, tx_sh[9:1]};
                  debug_wire_pin_oe <= ~tx_sh[1];
                  bitn              <= bitn + 4'h1;
                  cnt               <= {3'h0, bit_time} - 13'h0001;
               end
            end
            L_ERRBRK: begin
               if (cnt == `SDL_ERR_BRK_CYC - 13'h0001) begin
                  debug_wire_pin_oe <= 1'b0;
                  lstate            <= L_WAITHI;
               end else begin
                  cnt <= cnt + 13'h0001;
               end
            end
            L_WAITHI: begin
               debug_wire_pin_oe <= 1'b0;
               bit_time          <= `SDL_DIV_MAX;
               brk_lim           <= 14'h3fff;
               cstate            <= C_IDLE;
               tx_req            <= 1'b0;
               if (pin_s2) begin
                  lstate <= L_UNTRAINED;
               end
            end
            default: begin
               debug_wire_pin_oe <= 1'b0;
               lstate            <= L_UNTRAINED;
            end
         endcase
      end
   end

   // Control write with read lock guard and break opcode handling
   always @* begin
      next_ctl = debug_control_reg;
      if (wr_ctl) begin
         next_ctl = wr_data;
         if (read_lock_option && debug_control_reg[`SDL_CTL_HALT]) begin
            next_ctl[`SDL_CTL_HALT] = 1'b1;
         end
      end
      if (break_opcode_decode && debug_control_reg[`SDL_CTL_BRKEN] &&
          !debug_control_reg[`SDL_CTL_BREAK_LOOP_BIT]) begin
         next_ctl[`SDL_CTL_HALT] = 1'b1; // set wins over clear
      end
      // Pin level seen once synchronised; through next_ctl so outputs agree
      if (boot_cnt == 2'h2 && !pin_s2) begin
         next_ctl[`SDL_CTL_HALT] = 1'b1;
      end
   end

   // Only rst_n resets this state; link errors leave it alone
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         debug_control_reg <= `SDL_CTL_RESET;
         debug_status_reg  <= 8'h00;
         cpu_fetch_stop    <= 1'b0;
         cpu_halt_exit     <= 1'b0;
         wdt_refresh       <= 1'b0;
         cpu_break_loop    <= 1'b0;
         sys_reset_req     <= 1'b0;
         boot_cnt          <= 2'h0;
      end else begin
         debug_control_reg <= next_ctl;
         if (boot_cnt != 2'h3) begin
            boot_cnt <= boot_cnt + 2'h1;
         end
         if (break_opcode_decode && debug_control_reg[`SDL_CTL_BRKEN] &&
             debug_control_reg[`SDL_CTL_BREAK_LOOP_BIT]) begin
            cpu_break_loop <= 1'b1;
         end else if (next_ctl[`SDL_CTL_HALT] || !next_ctl[`SDL_CTL_BRKEN]) begin
            cpu_break_loop <= 1'b0;
         end
         cpu_fetch_stop <= next_ctl[`SDL_CTL_HALT];
         cpu_halt_exit  <= next_ctl[`SDL_CTL_HALT];
         wdt_refresh    <= next_ctl[`SDL_CTL_HALT];
         debug_status_reg                  <= 8'h00;
         debug_status_reg[`SDL_STAT_HALT]  <= next_ctl[`SDL_CTL_HALT];
         debug_status_reg[`SDL_STAT_LOOP]  <= looping;
         debug_status_reg[`SDL_STAT_LOCK]  <= read_lock_option;
         sys_reset_req <= stop_mode & ~pin_s2 & (boot_cnt == 2'h3);
      end
   end
endmodule // sdl_debug_link

// ---- test/sdl_debug_link_sva.sv ----
`timescale 1ns/1ps
`include "sdl_defines.vh"
module sdl_debug_link_sva (
   input wire logic       core_clk,
   input wire logic       rst_n,
   input wire logic       debug_wire_pin_in,
   input wire logic       debug_wire_pin_out,
   input wire logic       debug_wire_pin_oe,
   input wire logic       break_opcode_decode,
   input wire logic       stop_mode,
   input wire logic       read_lock_option,
   input wire logic [7:0] debug_control_reg,
   input wire logic [7:0] debug_status_reg,
   input wire logic       cpu_fetch_stop,
   input wire logic       cpu_halt_exit,
   input wire logic       wdt_refresh,
   input wire logic       cpu_break_loop,
   input wire logic       sys_reset_req,
   input wire logic       link_error
);
   logic [3:0]  age;
   logic [12:0] brk_run;
   logic        err_seen;
   logic        oe_q;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Age guards $past against values left over from reset
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         age      <= 4'h0;
         brk_run  <= 13'h0000;
         err_seen <= 1'b0;
         oe_q     <= 1'b0;
      end else begin
         if (age != 4'hf) age <= age + 4'h1;
         oe_q <= debug_wire_pin_oe;
         if (!debug_wire_pin_oe) brk_run <= 13'h0000;
         else if (brk_run != 13'h1fff) brk_run <= brk_run + 13'h0001;
         if (link_error) err_seen <= 1'b1;
         else if (oe_q && !debug_wire_pin_oe) err_seen <= 1'b0;
      end
   end
   a_drive_low: assert property (debug_wire_pin_oe |-> debug_wire_pin_out == 1'b0)
      else $error("pin driven high");
   a_idle_boot: assert property (age != 4'hf |-> !debug_wire_pin_oe)
      else $error("pin driven before any traffic");
   a_halt_fetch: assert property ($stable(debug_control_reg[7]) |->
      cpu_fetch_stop == debug_control_reg[7] && cpu_halt_exit == cpu_fetch_stop
      && wdt_refresh == cpu_fetch_stop) else $error("cpu controls disagree with halt");
   a_stat_track: assert property (age >= 4'h2 |->
      debug_status_reg[7] == debug_control_reg[7] && debug_status_reg[5] == $past(cpu_break_loop)
      && debug_status_reg[4] == $past(read_lock_option) && debug_status_reg[6] == 1'b0
      && debug_status_reg[3:0] == 4'h0) else $error("status out of step");
   a_brk_halt: assert property (break_opcode_decode && debug_control_reg[6]
      && !debug_control_reg[5] |=> debug_control_reg[7]) else $error("break opcode missed");
   a_brk_loop: assert property (break_opcode_decode && debug_control_reg[6]
      && debug_control_reg[5] && !debug_control_reg[7] |=> cpu_break_loop)
      else $error("loop not started");
   a_lock_keep: assert property (read_lock_option && debug_control_reg[7]
      |=> debug_control_reg[7]) else $error("halt cleared under lock");
   a_err_drive: assert property ($rose(link_error) |-> ##[0:3] debug_wire_pin_oe)
      else $error("no break after error");
   a_brk_len: assert property ($fell(debug_wire_pin_oe) && err_seen
      |-> brk_run == `SDL_ERR_BRK_CYC) else $error("error break length wrong");
   a_sysrst_set: assert property ((age == 4'hf && stop_mode && !debug_wire_pin_in)[*6]
      |-> sys_reset_req) else $error("stop mode pin reset missing");
   a_sysrst_cause: assert property ((!stop_mode)[*4] |-> !sys_reset_req)
      else $error("reset request without stop mode");
endmodule // sdl_debug_link_sva

bind sdl_debug_link sdl_debug_link_sva sdl_debug_link_sva_inst (
   .core_clk(core_clk), .rst_n(rst_n), .debug_wire_pin_in(debug_wire_pin_in),
   .debug_wire_pin_out(debug_wire_pin_out), .debug_wire_pin_oe(debug_wire_pin_oe),
   .break_opcode_decode(break_opcode_decode), .stop_mode(stop_mode),
   .read_lock_option(read_lock_option), .debug_control_reg(debug_control_reg),
   .debug_status_reg(debug_status_reg), .cpu_fetch_stop(cpu_fetch_stop),
   .cpu_halt_exit(cpu_halt_exit), .wdt_refresh(wdt_refresh),
   .cpu_break_loop(cpu_break_loop), .sys_reset_req(sys_reset_req),
   .link_error(link_error)
);

// ---- test/sdl_host_model.sv ----
`timescale 1ns/1ps
module sdl_host_model #(
   parameter int BIT = 8
) (
   input  wire logic core_clk,
   input  wire logic line,
   output logic      host_low
);
   initial host_low = 1'b0;
   task automatic hold(input logic v);
      host_low <= v;
   endtask
   task automatic send_frame(input logic [7:0] b, input logic stop_bit);
      logic [9:0] f;
      f = {stop_bit, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge core_clk);
         host_low <= ~f[i];                       // Low start, LSB first
         repeat (BIT - 1) @(posedge core_clk);
      end
      @(posedge core_clk);
      host_low <= 1'b0;                           // Only pulls low, pull-up idles
   endtask
   task automatic send_break(input int n);
      @(posedge core_clk);
      host_low <= 1'b1;
      repeat (n) @(posedge core_clk);
      host_low <= 1'b0;
   endtask
   // Samples mid-bit; a missing reply returns ok low
   task automatic recv_frame(output logic [7:0] b, output logic ok);
      int n;
      n = 0;
      b = 8'h00;
      ok = 1'b0;
      while (line === 1'b1 && n < 2000) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 2000) return;
      repeat (BIT / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge core_clk);
         b[i] = line;
      end
      repeat (BIT) @(posedge core_clk);
      ok = line;
   endtask
endmodule // sdl_host_model

// ---- test/tb.sv ----
`timescale 1ns/1ps
`include "sdl_defines.vh"
module tb;
   localparam int BIT = 8;  // Divide by 8, the recommended ceiling
   logic       core_clk;
   logic       rst_n;
   logic       brk_dec;
   logic       stop_mode;
   logic       rd_lock;
   logic       host_low;
   logic       pin_out;
   logic       pin_oe;
   logic [7:0] ctl;
   logic [7:0] stat;
   logic       fetch_stop;
   logic       halt_exit;
   logic       wdt_ref;
   logic       brk_loop;
   logic       sys_rst;
   logic       link_err;
   wire        line;
   int         bad_count;
   int         samples_checked;
   int         err_n;
   int         brk_n;
   int         run;
   int         last_run;
   int         e0;
   int         b0;
   int         n;
   logic [7:0] rb;
   logic       rok;
   logic [7:0] rows_wr [5] = '{8'h80, 8'h00, 8'h40, 8'h5a, 8'ha5};
   logic [7:0] rows_st [5] = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h80};

   assign line = (pin_oe ? pin_out : 1'b1) & ~host_low;  // Open drain with pull-up
   sdl_debug_link sdl_debug_link_inst (
      .core_clk(core_clk), .rst_n(rst_n), .debug_wire_pin_in(line),
      .debug_wire_pin_out(pin_out), .debug_wire_pin_oe(pin_oe),
      .break_opcode_decode(brk_dec), .stop_mode(stop_mode), .read_lock_option(rd_lock),
      .debug_control_reg(ctl), .debug_status_reg(stat), .cpu_fetch_stop(fetch_stop),
      .cpu_halt_exit(halt_exit), .wdt_refresh(wdt_ref), .cpu_break_loop(brk_loop),
      .sys_reset_req(sys_rst), .link_error(link_err)
   );
   sdl_host_model #(.BIT(BIT)) host (.core_clk(core_clk), .line(line), .host_low(host_low));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   // Long drive runs are error breaks; tx bits stay far shorter
   always @(posedge core_clk) begin
      if (link_err === 1'b1) err_n <= err_n + 1;
      if (pin_oe === 1'b1) run <= run + 1;
      else if (run != 0) begin
         if (run > 100) begin
            last_run <= run;
            brk_n <= brk_n + 1;
         end
         run <= 0;
      end
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
   endtask
   task automatic wr_ctl(input logic [7:0] v);
      host.send_frame(`SDL_CMD_WR_CTL, 1'b1);
      host.send_frame(v, 1'b1);
      cyc(BIT);
   endtask
   task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
      logic [7:0] b;
      logic       ok;
      host.send_frame(cmd, 1'b1);
      host.recv_frame(b, ok);
      check({15'h0000, ok}, 16'h0001);
      check({8'h00, b}, {8'h00, exp});
      if (ok !== 1'b1) begin
         report_and_stop();
      end
      cyc(BIT);
   endtask
   task automatic pulse();
      @(posedge core_clk);
      brk_dec <= 1'b1;
      @(posedge core_clk);
      brk_dec <= 1'b0;
      cyc(2);
   endtask
   task automatic recover();
      n = 0;
      while (brk_n == b0 && n < 6000) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 6000) begin
         bad_count++;
         report_and_stop();
      end
      check({15'h0000, err_n != e0}, 16'h0001);
      check(last_run[15:0], {3'b000, `SDL_ERR_BRK_CYC});
      cyc(BIT);
      host.send_frame(`SDL_SYNC_CHAR, 1'b1);             // Retrain after error
      cyc(BIT);
   endtask

   initial begin
      rst_n = 1'b0;
      brk_dec = 1'b0;
      stop_mode = 1'b0;
      rd_lock = 1'b0;
      host.hold(1'b1);
      cyc(2);
      check({7'h00, pin_oe, ctl}, {8'h00, `SDL_CTL_RESET});
      rst_n <= 1'b1;
      cyc(6);
      host.hold(1'b0);
      cyc(4);
      check({15'h0000, fetch_stop}, 16'h0001);
      host.send_frame(`SDL_SYNC_CHAR, 1'b1);
      for (int i = 0; i < 5; i++) begin
         wr_ctl(rows_wr[i]);
         check({8'h00, ctl}, {8'h00, rows_wr[i]});
         check({8'h00, stat}, {8'h00, rows_st[i]});
         check({13'h0000, fetch_stop, halt_exit, wdt_ref}, {13'h0000, {3{rows_wr[i][7]}}});
         rd(`SDL_CMD_RD_CTL, rows_wr[i]);
         rd(`SDL_CMD_RD_STAT, rows_st[i]);
      end
      wr_ctl(8'h00);
      pulse();
      check({8'h00, ctl}, 16'h0000);
      wr_ctl(8'h40);
      pulse();
      check({8'h00, ctl}, 16'h00c0);
      wr_ctl(8'h60);
      pulse();
      check({14'h0000, brk_loop, ctl[7]}, 16'h0002);
      rd(`SDL_CMD_RD_STAT, 8'h20);
      host.send_frame(8'h0b, 1'b1);                   // Memory read gets no reply
      host.recv_frame(rb, rok);
      check({15'h0000, rok}, 16'h0000);
      wr_ctl(8'h40);                                  // Host clears the loop bit
      check({15'h0000, brk_loop}, 16'h0001);
      pulse();
      check({14'h0000, brk_loop, ctl[7]}, 16'h0001);
      rd_lock <= 1'b1;
      wr_ctl(8'h00);
      check({8'h00, ctl}, 16'h0080);
      rd(`SDL_CMD_RD_STAT, 8'h90);
      rd_lock <= 1'b0;
      e0 = err_n;
      b0 = brk_n;
      host.send_frame(8'h55, 1'b0);
      recover();
      check({8'h00, ctl}, 16'h0080);
      e0 = err_n;
      b0 = brk_n;
      host.send_break(25 * BIT);                      // Host error recovery
      recover();
      check({14'h0000, ctl[7], fetch_stop}, 16'h0003);
      rd(`SDL_CMD_RD_CTL, 8'h80);
      e0 = err_n;
      b0 = brk_n;
      host.send_frame(`SDL_CMD_RD_CTL, 1'b1);
      n = 0;
      while (pin_oe !== 1'b1 && n < 2000) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 2000) begin
         bad_count++;
         report_and_stop();
      end
      host.send_break(150);                           // Talks over reply bit 7
      recover();
      stop_mode <= 1'b1;
      cyc(8);
      check({15'h0000, sys_rst}, 16'h0000);
      host.hold(1'b1);
      cyc(8);
      check({15'h0000, sys_rst}, 16'h0001);
      host.hold(1'b0);
      stop_mode <= 1'b0;
      rst_n <= 1'b0;
      cyc(2);
      check({6'h00, fetch_stop, pin_oe, ctl}, 16'h0000);
      rst_n <= 1'b1;
      cyc(10);
      check({7'h00, pin_oe, ctl}, 16'h0000);
      report_and_stop();
   end
endmodule // tb
